// ==== adcc_params.svh ====
// Offsets, field positions, reset values and counts of the converter control
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
`define ADCC_OFF_SC 3'h0
`define ADCC_OFF_DATA 3'h1
`define ADCC_OFF_CLK 3'h2
`define ADCC_OFF_PDATA 3'h3
`define ADCC_OFF_PDIR 3'h4
`define ADCC_SC_DONE 7
`define ADCC_SC_IEN 6
`define ADCC_SC_CONT 5
`define ADCC_CLK_SRC 4
`define ADCC_CH_OFF 5'h1f
`define ADCC_CH_PINS 5'h06
`define ADCC_RST_CH 5'h1f
`define ADCC_SAMPLE_TICKS 4'h9
`define ADCC_CONV_TICKS 5'h11
`define ADCC_MSB 3'h7
`define ADCC_MSB_CODE 8'h80
`endif

// ==== adcc_pkg.sv ====
// Types shared by the converter control modules
package adcc_pkg;
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_CONV = 2'b11
  } adcc_sar_st_t;
  typedef struct packed {
    adcc_sar_st_t st;
    logic [3:0] cnt;
    logic [2:0] bitx;
    logic [7:0] code;
    logic [7:0] result;
    logic done;
  } adcc_sar_t;
  typedef struct packed {
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [3:0] div;
    logic tick;
  } adcc_clk_t;
  typedef struct packed {
    logic sc_done;
    logic ien;
    logic cont;
    logic [4:0] ch;
    logic [2:0] prescale;
    logic src;
    logic [7:0] data;
    logic [5:0] port_data;
    logic [5:0] port_dir;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic irq_pend;
    logic stop_prev;
    logic resume;
    logic [7:0] rdata;
    logic irq;
    logic dma;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [4:0] mux_sel;
    logic pwr_down;
  } adcc_ctl_t;
endpackage

// ==== adcc_sar_if.sv ====
// Signals between the control, the clock divider and the sequencer
`timescale 1ns/100ps
`default_nettype none
interface adcc_sar_if;
  logic tick;
  logic start;
  logic abort;
  logic cmp_ge;
  logic done;
  logic busy;
  logic src_bus;
  logic [2:0] prescale;
  logic [7:0] code;
  logic [7:0] result;
  modport ctl (input tick, done, busy, result, code,
    output start, abort, cmp_ge, src_bus, prescale);
  modport sar (input tick, start, abort, cmp_ge,
    output done, busy, code, result);
  modport clkgen (input src_bus, prescale, output tick);
endinterface
`default_nettype wire

// ==== adcc_clkgen.sv ====
// Converter clock tick: source select and prescaler
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
module adcc_clkgen
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // External reference clock, synchronised and counted on its rising edges
  input wire logic ext_ref_clk,
  // Tick to the sequencer
  adcc_sar_if.clkgen sif
);
  adcc_clk_t s_reg;
  adcc_clk_t s_next;
  logic [3:0] mask;
  logic base;

  always_comb begin
    s_next = s_reg;
    unique casez (sif.prescale)
      3'b000: mask = 4'h0;
      3'b001: mask = 4'h1;
      3'b010: mask = 4'h3;
      3'b011: mask = 4'h7;
      3'b1??: mask = 4'hf;
    endcase
    s_next.ext_sync = {s_reg.ext_sync[0], ext_ref_clk};
    s_next.ext_prev = s_reg.ext_sync[1];
    // Bus clock gives a base tick every cycle, else a reference edge
    base = sif.src_bus | (s_reg.ext_sync[1] & ~s_reg.ext_prev);
    s_next.tick = 1'b0;
    if (base) begin
      s_next.div = s_reg.div + 4'h1;
      s_next.tick = ((s_reg.div & mask) == mask);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sif.tick = s_reg.tick;
endmodule
`default_nettype wire

// ==== adcc_sar.sv ====
// Successive approximation sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
module adcc_sar
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  adcc_sar_if.sar sif
);
  adcc_sar_t s_reg;
  adcc_sar_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      SAR_IDLE: begin
      end
      SAR_SAMPLE: begin
        if (sif.tick) begin
          if (s_reg.cnt == `ADCC_SAMPLE_TICKS - 4'h1) begin
            s_next.st = SAR_CONV;
            s_next.bitx = `ADCC_MSB;
            s_next.code = `ADCC_MSB_CODE;
          end else begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end
        end
      end
      SAR_CONV: begin
        if (sif.tick) begin
          // Trial bit stays only while the input is at or above it
          s_next.code[s_reg.bitx] = sif.cmp_ge;
          if (s_reg.bitx == 3'h0) begin
            s_next.st = SAR_IDLE;
            s_next.result = {s_reg.code[7:1], sif.cmp_ge};
            s_next.done = 1'b1;
          end else begin
            s_next.code[s_reg.bitx - 3'h1] = 1'b1;
            s_next.bitx = s_reg.bitx - 3'h1;
          end
        end
      end
    endcase
    if (sif.abort) begin
      s_next.st = SAR_IDLE;
      s_next.done = 1'b0;
    end
    // A restart drops any completion still in flight
    if (sif.start) begin
      s_next.st = SAR_SAMPLE;
      s_next.cnt = 4'h0;
      s_next.code = 8'h00;
      s_next.done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sif.busy = (s_reg.st != SAR_IDLE);
  assign sif.done = s_reg.done;
  assign sif.code = s_reg.code;
  assign sif.result = s_reg.result;
endmodule
`default_nettype wire

// ==== adcc_top.sv ====
// Converter control: registers, pin override, sequencing and requests
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Low power state from the processor
  input wire logic stop_mode,
  // Shared analog pins
  input wire logic [5:0] shared_analog_pins_in,
  output logic [5:0] shared_analog_pins_out,
  output logic [5:0] shared_analog_pins_oe,
  // External reference clock
  input wire logic external_reference_clock,
  // Analog core
  input wire logic cmp_ge,
  output logic [7:0] dac_code,
  output logic [4:0] selected_analog_input,
  output logic analog_power_down,
  // Requests
  output logic cpu_irq,
  output logic dma_req
);
  adcc_ctl_t s_reg;
  adcc_ctl_t s_next;
  adcc_sar_if sif ();

  logic sc_wr;
  logic clk_wr;
  logic pd_wr;
  logic dir_wr;
  logic data_rd;
  logic [4:0] ch_now;
  logic ien_now;
  logic off_now;
  logic stop_rise;
  logic stop_fall;
  logic [5:0] claim;
  logic [5:0] pd_next;
  logic [5:0] dir_next;
  logic [5:0] pin_rd;

  assign sc_wr = reg_wr && (reg_addr == `ADCC_OFF_SC);
  assign clk_wr = reg_wr && (reg_addr == `ADCC_OFF_CLK);
  assign pd_wr = reg_wr && (reg_addr == `ADCC_OFF_PDATA);
  assign dir_wr = reg_wr && (reg_addr == `ADCC_OFF_PDIR);
  assign data_rd = reg_rd && (reg_addr == `ADCC_OFF_DATA);
  assign ch_now = sc_wr ? reg_wdata[4:0] : s_reg.ch;
  assign ien_now = sc_wr ? reg_wdata[`ADCC_SC_IEN] : s_reg.ien;
  assign off_now = (ch_now == `ADCC_CH_OFF);
  assign stop_rise = stop_mode && !s_reg.stop_prev;
  assign stop_fall = !stop_mode && s_reg.stop_prev;

  // Per pin: claim, write masking and read back
  // A claimed pin keeps its latch bits, so it drives as before once freed
  genvar i;
  for (i = 0; i < 6; i++) begin : g_pin
    assign claim[i] = (ch_now == 5'(i));
    assign pd_next[i] = (pd_wr && !claim[i]) ? reg_wdata[i] :
      s_reg.port_data[i];
    assign dir_next[i] = (dir_wr && !claim[i]) ? reg_wdata[i] :
      s_reg.port_dir[i];
    assign pin_rd[i] = claim[i] ? 1'b0 :
      (s_reg.port_dir[i] ? s_reg.port_data[i] : s_reg.pin_s2[i]);
  end

  // Start and abort act in the same cycle so no stale result slips in
  always_comb begin
    sif.start = 1'b0;
    sif.abort = 1'b0;
    if (!stop_mode && !off_now) begin
      if (sc_wr) begin
        sif.start = 1'b1;
      end
      if (sif.done && s_reg.cont) begin
        sif.start = 1'b1;
      end
      if (stop_fall && s_reg.resume) begin
        sif.start = 1'b1;
      end
    end
    if (stop_rise || (sc_wr && off_now)) begin
      sif.abort = 1'b1;
    end
  end

  assign sif.cmp_ge = cmp_ge;
  assign sif.src_bus = s_reg.src;
  assign sif.prescale = s_reg.prescale;

  always_comb begin
    s_next = s_reg;
    s_next.pin_s1 = shared_analog_pins_in;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.stop_prev = stop_mode;
    s_next.port_data = pd_next;
    s_next.port_dir = dir_next;
    if (sc_wr) begin
      s_next.ien = reg_wdata[`ADCC_SC_IEN];
      s_next.cont = reg_wdata[`ADCC_SC_CONT];
      s_next.ch = reg_wdata[4:0];
      // Enabled: the bit is a stored select, else the write clears it
      s_next.sc_done = reg_wdata[`ADCC_SC_DONE] & ien_now;
    end
    if (data_rd && !s_reg.ien) begin
      s_next.sc_done = 1'b0;
    end
    if (clk_wr) begin
      s_next.prescale = reg_wdata[7:5];
      s_next.src = reg_wdata[`ADCC_CLK_SRC];
    end
    if (sc_wr || data_rd) begin
      s_next.irq_pend = 1'b0;
    end
    if (sif.done) begin
      s_next.data = sif.result;
      if (ien_now) begin
        s_next.irq_pend = 1'b1;
      end else begin
        s_next.sc_done = 1'b1;
      end
    end
    // Stop remembers whether work was under way so it can resume
    if (stop_rise) begin
      s_next.resume = sif.busy | s_reg.cont;
    end
    if (stop_mode && sc_wr) begin
      s_next.resume = 1'b1;
    end
    if (!ien_now) begin
      s_next.irq_pend = 1'b0;
    end
    // Requests stay live in wait mode so they can wake the core
    s_next.irq = s_next.irq_pend & ~s_next.sc_done;
    s_next.dma = s_next.irq_pend & s_next.sc_done;
    s_next.pin_out = pd_next;
    s_next.pin_oe = dir_next & ~claim;
    s_next.mux_sel = ch_now;
    s_next.pwr_down = off_now;
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADCC_OFF_SC: s_next.rdata = {s_reg.sc_done, s_reg.ien,
          s_reg.cont, s_reg.ch};
        `ADCC_OFF_DATA: s_next.rdata = s_reg.data;
        `ADCC_OFF_CLK: s_next.rdata = {s_reg.prescale, s_reg.src, 4'h0};
        `ADCC_OFF_PDATA: s_next.rdata = {2'h0, pin_rd};
        `ADCC_OFF_PDIR: s_next.rdata = {2'h0, s_reg.port_dir};
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ch <= `ADCC_RST_CH;
      s_reg.pwr_down <= 1'b1;
      s_reg.mux_sel <= `ADCC_RST_CH;
    end else begin
      s_reg <= s_next;
    end
  end

  adcc_clkgen u_clkgen (
    .clk(clk),
    .rst(rst),
    .ext_ref_clk(external_reference_clock),
    .sif(sif.clkgen)
  );

  adcc_sar u_sar (
    .clk(clk),
    .rst(rst),
    .sif(sif.sar)
  );

  assign reg_rdata = s_reg.rdata;
  assign shared_analog_pins_out = s_reg.pin_out;
  assign shared_analog_pins_oe = s_reg.pin_oe;
  assign dac_code = sif.code;
  assign selected_analog_input = s_reg.mux_sel;
  assign analog_power_down = s_reg.pwr_down;
  assign cpu_irq = s_reg.irq;
  assign dma_req = s_reg.dma;

  // Checking aids
  logic [4:0] tick_cnt;
  always_ff @(posedge clk) begin
    if (rst || sif.start) begin
      tick_cnt <= 5'h00;
    end else if (sif.tick && sif.busy) begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Completion with no control write or stop beside it, so nothing else moves
  sequence conv_end;
    sif.done && !sc_wr && !stop_mode;
  endsequence
  sequence ctl_write_on;
    sc_wr && (reg_wdata[4:0] != `ADCC_CH_OFF) && !stop_mode;
  endsequence

  claimed_pin_oe_a: assert property (
    (s_reg.ch < `ADCC_CH_PINS) |-> !shared_analog_pins_oe[s_reg.ch[2:0]])
    else $error("claimed pin still driven");
  claimed_read_a: assert property (
    reg_rd && (reg_addr == `ADCC_OFF_PDATA) && (s_reg.ch < `ADCC_CH_PINS)
    |=> !reg_rdata[s_reg.ch[2:0]])
    else $error("claimed pin read not zero");
  write_starts_a: assert property (
    ctl_write_on |=> sif.busy [*2])
    else $error("control write did not start conversion");
  conv_ticks_a: assert property (
    sif.done |-> (tick_cnt == `ADCC_CONV_TICKS))
    else $error("conversion length wrong");
  result_store_a: assert property (
    sif.done |=> (s_reg.data == $past(sif.result)))
    else $error("result not stored");
  cont_restart_a: assert property (
    conv_end ##0 (s_reg.cont && (s_reg.ch != `ADCC_CH_OFF))
    |=> sif.busy)
    else $error("continuous mode did not restart");
  single_once_a: assert property (
    conv_end ##0 !s_reg.cont |=> !sif.busy)
    else $error("single mode restarted");
  done_set_a: assert property (
    conv_end ##0 !s_reg.ien |=> s_reg.sc_done && !cpu_irq && !dma_req)
    else $error("done bit not set");
  done_clear_a: assert property (
    data_rd && !s_reg.ien && !sif.done |=> !s_reg.sc_done)
    else $error("done bit not cleared by read");
  irq_route_a: assert property (
    conv_end ##0 s_reg.ien
    |=> (cpu_irq == !s_reg.sc_done) && (dma_req == s_reg.sc_done))
    else $error("request routed wrongly");
  req_clear_a: assert property (
    (sc_wr || data_rd) && !sif.done |=> !cpu_irq && !dma_req)
    else $error("request not cleared");
  stop_abort_a: assert property (
    stop_rise |=> !sif.busy && !sif.done)
    else $error("stop did not abort");
  power_off_a: assert property (
    sc_wr && (reg_wdata[4:0] == `ADCC_CH_OFF)
    |=> analog_power_down && !sif.busy)
    else $error("power off not taken");
  mux_follow_a: assert property (
    selected_analog_input == s_reg.ch)
    else $error("mux select not following channel");
  select_store_a: assert property (
    sc_wr && reg_wdata[`ADCC_SC_IEN]
    |=> s_reg.sc_done == $past(reg_wdata[`ADCC_SC_DONE]))
    else $error("select bit not stored");
  claimed_keep_a: assert property (
    dir_wr
    |=> ((s_reg.port_dir ^ $past(s_reg.port_dir)) & $past(claim)) == 6'h00)
    else $error("claimed pin direction changed");
  stop_idle_a: assert property (
    stop_mode && s_reg.stop_prev |-> !sif.busy)
    else $error("converter busy in stop");
  disabled_quiet_a: assert property (
    !s_reg.ien |-> !cpu_irq && !dma_req)
    else $error("request while disabled");
endmodule
`default_nettype wire

// ==== adcc_src_model.sv ====
// Analog source and comparator on the far side of the converter
`timescale 1ns/100ps
`default_nettype none
module adcc_src_model (
  // Trial code from the converter
  input wire logic [7:0] dac_code,
  // Source level, 255 and above stand for the high reference
  input wire logic [8:0] level,
  // Comparator answer, settles within the cycle
  output logic cmp_ge
);
  // Levels past full scale still compare high against every code
  assign cmp_ge = level >= {1'b0, dac_code};
endmodule
`default_nettype wire

// ==== adc_conversion_control_tb_top.sv ====
// Self-checking bench for the converter control
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic stop_mode = 1'b0;
  logic [5:0] pins_in = 6'h00;
  logic [5:0] pins_out;
  logic [5:0] pins_oe;
  logic ext_clk = 1'b0;
  logic cmp_ge;
  logic [7:0] dac_code;
  logic [4:0] sel;
  logic pwr_down;
  logic cpu_irq;
  logic dma_req;
  logic [8:0] level = 9'h000;
  integer seed = 32'he7eea93f;
  integer failures = 0;
  integer comparisons = 0;
  integer cyc;
  logic [7:0] rv;
  logic [4:0] ch;
  logic [5:0] m;
  logic [7:0] reg_wdata_q;
  logic [7:0] cfgs [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hf0, 8'h00};
  integer divs [7] = '{1, 2, 4, 8, 16, 16, 6};

  always #2.5 clk = ~clk;
  // Reference clock at one sixth of the bus rate, free phase
  always #15.3 ext_clk = ~ext_clk;

  adcc_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stop_mode(stop_mode),
    .shared_analog_pins_in(pins_in), .shared_analog_pins_out(pins_out),
    .shared_analog_pins_oe(pins_oe), .external_reference_clock(ext_clk),
    .cmp_ge(cmp_ge), .dac_code(dac_code), .selected_analog_input(sel),
    .analog_power_down(pwr_down), .cpu_irq(cpu_irq), .dma_req(dma_req));

  adcc_src_model src (.dac_code(dac_code), .level(level), .cmp_ge(cmp_ge));

  function automatic logic [7:0] expv(input logic [8:0] l);
    return (l > 9'h0ff) ? 8'hff : l[7:0];
  endfunction

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_req(input integer lim);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc = cyc + 1;
    end while (cpu_irq !== 1'b1 && dma_req !== 1'b1 && cyc < lim);
  endtask

  task automatic wait_done;
    integer n;
    n = 0;
    do begin
      rd(3'h0, rv);
      n = n + 1;
    end while (rv[7] !== 1'b1 && n < 40);
  endtask

  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    failures = failures + 1;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(3'h0, rv);
    chk("ctrl reset", rv, 8'h1f);
    chk("power down", pwr_down, 1'b1);
    chk("reset outs", {cpu_irq, dma_req, pins_oe, pins_out, dac_code},
      22'h0);
    rd(3'h2, rv);
    chk("clk cfg reset", rv, 8'h00);
    rd(3'h5, rv);
    chk("unmapped read", rv, 8'h00);
    $display("test reset done");
    // Prescale codes 0 to 4 and 7 on the bus clock, code 0 on the reference clock, corner levels first
    for (int i = 0; i < 7; i++) begin
      ch = 5'({$random(seed)} % 6);
      rv = $random(seed);
      level <= (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : {1'b0, rv};
      wr(3'h2, cfgs[i]);
      wr(3'h0, {3'b010, ch});
      wait_req(400);
      chk("conv time", cyc >= 16 * divs[i] && cyc <= 17 * divs[i] + 8,
        1);
      chk("cpu req", {cpu_irq, dma_req}, 2'b10);
      chk("mux", sel, ch);
      chk("dac code", dac_code, expv(level));
      chk("pin oe", pins_oe[ch], 1'b0);
      rd(3'h1, rv);
      chk("result", rv, expv(level));
      chk("req cleared", cpu_irq, 1'b0);
    end
    $display("test timing done");
    wr(3'h2, 8'h10);
    wr(3'h0, {3'b110, ch});
    wait_req(100);
    chk("dma req", {cpu_irq, dma_req}, 2'b01);
    rd(3'h0, rv);
    chk("dma select", rv, {3'b110, ch});
    wr(3'h0, {3'b100, ch});
    #1;
    chk("write clears", dma_req, 1'b0);
    $display("test dma done");
    wait_done();
    chk("done flag", rv[7], 1'b1);
    wr(3'h0, {3'b100, ch});
    rd(3'h0, rv);
    chk("done write", rv, {3'b000, ch});
    wait_done();
    rd(3'h1, rv);
    rd(3'h0, rv);
    chk("done read", rv[7], 1'b0);
    repeat (60) @(posedge clk);
    rd(3'h0, rv);
    chk("single once", rv[7], 1'b0);
    $display("test flag done");
    wr(3'h0, {3'b001, ch});
    repeat (30) @(posedge clk);
    rv = $random(seed);
    level <= {1'b0, rv};
    repeat (60) @(posedge clk);
    rd(3'h0, rv);
    chk("cont flag", rv[7], 1'b1);
    rd(3'h1, rv);
    chk("cont data", rv, expv(level));
    level <= 9'h0a5;
    repeat (60) @(posedge clk);
    rd(3'h1, rv);
    chk("cont again", rv, 8'ha5);
    wr(3'h0, {3'b000, ch});
    repeat (60) @(posedge clk);
    level <= 9'h05a;
    repeat (60) @(posedge clk);
    rd(3'h1, rv);
    chk("cont stopped", rv, 8'ha5);
    $display("test continuous done");
    m = 6'h01 << ch;
    pins_in <= 6'($random(seed));
    rv = $random(seed);
    wr(3'h4, rv);
    wr(3'h3, 8'h3f);
    repeat (3) @(posedge clk);
    rd(3'h3, reg_wdata_q);
    chk("port read", reg_wdata_q[5:0],
      (rv[5:0] | (~rv[5:0] & pins_in)) & ~m);
    chk("port oe", pins_oe, rv[5:0] & ~m);
    chk("pin out", pins_out, 6'h3f & ~m);
    $display("test port done");
    wr(3'h2, 8'h90);
    wr(3'h0, {3'b010, ch});
    repeat (50) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (400) @(posedge clk);
    #1;
    chk("stop abort", cpu_irq, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b0;
    wait_req(400);
    chk("stop resume", cpu_irq, 1'b1);
    wr(3'h2, 8'h10);
    wr(3'h0, 8'h5f);
    wait_req(100);
    chk("off no req", {cpu_irq, pwr_down}, 2'b01);
    $display("test low power done");
    test_done();
  end
endmodule
`default_nettype wire
